// File: common/rbs_cfg_if.sv
`timescale 1ns/1ps
// one port's configuration, from the register slice to the data path
interface rbs_cfg_if;
    logic        enable;     // tester path on
    logic        direction;  // source select
    logic [7:0]  suppress;   // per bit-position exclusion
    logic [31:0] chsel;      // per timeslot selection
    modport owner (output enable, output direction,
                   output suppress, output chsel);
    modport user  (input enable, input direction,
                   input suppress, input chsel);
endinterface

// File: common/rbs_pkg.sv
// shared constants for the receive tester channel selector
package rbs_pkg;
    // port replication and register spacing
    localparam int           NUM_PORTS   = 4;
    localparam int           PORT_W      = 2;
    localparam int           OFF_W       = 9;     // register index bits
    localparam int           ADDR_W      = 13;    // byte address width
    localparam logic [10:0]  PORT_STRIDE = 11'h200;
    // register indices inside one port (byte address is four times)
    localparam logic [8:0]   OFF_CTRL    = 9'h08a;
    localparam logic [8:0]   OFF_SUPP    = 9'h08b;
    localparam logic [8:0]   OFF_CSEL1   = 9'h0d4;
    localparam logic [8:0]   OFF_CSEL2   = 9'h0d5;
    localparam logic [8:0]   OFF_CSEL3   = 9'h0d6;
    localparam logic [8:0]   OFF_CSEL4   = 9'h0d7;
    // control register fields
    localparam int           CTRL_EN_BIT  = 0;
    localparam int           CTRL_DIR_BIT = 2;
    localparam logic [7:0]   CTRL_RST     = 8'h00;
    localparam logic [7:0]   SUPP_RST     = 8'h00;
    localparam logic [31:0]  CSEL_RST     = 32'h0000_0000;
    // direction encodings
    localparam logic         DIR_LINE      = 1'b0;
    localparam logic         DIR_BACKPLANE = 1'b1;
    // channel and bit geometry
    localparam int           NUM_CH   = 32;
    localparam int           CH_W     = 5;
    localparam int           BITPOS_W = 3;
    // clock and buffer figures
    localparam int           CLK_PERIOD_NS = 8;
    localparam int           FIFO_DEPTH    = 4;
endpackage

// File: src/rbs_fifo.sv
`timescale 1ns/1ps
// small synchronous fifo with valid/ready on both sides
module rbs_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = rbs_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // pointer arithmetic relies on wrap at a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
        $error("rbs_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];   // storage words
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW:0]      wp_r, wp_nxt;    // write pointer, extra wrap bit
    logic [AW:0]      rp_r, rp_nxt;    // read pointer, extra wrap bit
    logic             full, empty;

    assign empty     = (wp_r == rp_r);
    assign full      = (wp_r[AW] != rp_r[AW]) &&
                       (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign in_ready  = ~full & ~clear;
    assign out_valid = ~empty;
    assign out_data  = mem_r[rp_r[AW-1:0]];

    // next pointers and storage; clear drops all words at once
    always_comb begin
        mem_nxt = mem_r;
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        if (clear) begin
            wp_nxt = '0;
            rp_nxt = '0;
        end else begin
            if (in_valid && in_ready) begin
                mem_nxt[wp_r[AW-1:0]] = in_data;
                wp_nxt = wp_r + 1'b1;
            end
            if (out_valid && out_ready)
                rp_nxt = rp_r + 1'b1;
        end
    end

    // register stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            for (int i = 0; i < DEPTH; i++)
                mem_r[i] <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            mem_r <= mem_nxt;
        end
    end
endmodule

// File: src/rbs_port_regs.sv
`timescale 1ns/1ps
// register slice of one port: control, suppress, four select bytes
module rbs_port_regs (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic [8:0] off,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data,
    output logic            hit,
    rbs_cfg_if.owner        cfg
);
    logic        en_r, en_nxt;       // tester enable
    logic        dir_r, dir_nxt;     // source direction
    logic [7:0]  supp_r, supp_nxt;   // bit suppress mask
    logic [31:0] csel_r, csel_nxt;   // channel select, ch1 at bit 0

    // decode and next values; unused control bits are not stored
    always_comb begin
        en_nxt   = en_r;
        dir_nxt  = dir_r;
        supp_nxt = supp_r;
        csel_nxt = csel_r;
        hit      = 1'b1;
        rd_data  = 8'h00;
        unique case (off)
            rbs_pkg::OFF_CTRL: begin
                rd_data[rbs_pkg::CTRL_EN_BIT]  = en_r;
                rd_data[rbs_pkg::CTRL_DIR_BIT] = dir_r;
                if (wr_en) begin
                    en_nxt  = wr_data[rbs_pkg::CTRL_EN_BIT];
                    dir_nxt = wr_data[rbs_pkg::CTRL_DIR_BIT];
                end
            end
            rbs_pkg::OFF_SUPP: begin
                rd_data = supp_r;
                if (wr_en)
                    supp_nxt = wr_data;
            end
            // byte k of the select vector holds channels 8k+1..8k+8
            rbs_pkg::OFF_CSEL1: begin
                rd_data = csel_r[7:0];
                if (wr_en)
                    csel_nxt[7:0] = wr_data;
            end
            rbs_pkg::OFF_CSEL2: begin
                rd_data = csel_r[15:8];
                if (wr_en)
                    csel_nxt[15:8] = wr_data;
            end
            rbs_pkg::OFF_CSEL3: begin
                rd_data = csel_r[23:16];
                if (wr_en)
                    csel_nxt[23:16] = wr_data;
            end
            rbs_pkg::OFF_CSEL4: begin
                rd_data = csel_r[31:24];
                if (wr_en)
                    csel_nxt[31:24] = wr_data;
            end
            // anything else is unmapped
            default: hit = 1'b0;
        endcase
    end

    // register stage, everything clear at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r   <= rbs_pkg::CTRL_RST[rbs_pkg::CTRL_EN_BIT];
            dir_r  <= rbs_pkg::CTRL_RST[rbs_pkg::CTRL_DIR_BIT];
            supp_r <= rbs_pkg::SUPP_RST;
            csel_r <= rbs_pkg::CSEL_RST;
        end else begin
            en_r   <= en_nxt;
            dir_r  <= dir_nxt;
            supp_r <= supp_nxt;
            csel_r <= csel_nxt;
        end
    end

    assign cfg.enable    = en_r;
    assign cfg.direction = dir_r;
    assign cfg.suppress  = supp_r;
    assign cfg.chsel     = csel_r;
endmodule

// File: src/rbs_top.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
//
// Contract
// - enable bit zero blocks the tester path
// - direction picks line inputs or backplane
// - 32 select bits, ch1 lsb of first byte
// - select bits ignored while disabled
// - any select combination, all 32 allowed
// - uses receive framer timing only
// - mask bit excludes that bit position
// - four ports, bases 0x200 apart
//
module rbs_top #(
    parameter int FIFO_DEPTH = rbs_pkg::FIFO_DEPTH
) (
    input  wire logic                            SYS_CLK,
    input  wire logic                            NRST,
    // apb slave
    input  wire logic                            PSEL,
    input  wire logic                            PENABLE,
    input  wire logic                            PWRITE,
    input  wire logic [rbs_pkg::ADDR_W-1:0]      PADDR,
    input  wire logic [31:0]                     PWDATA,
    output logic      [31:0]                     PRDATA,
    output logic                                 PREADY,
    output logic                                 PSLVERR,
    // receive framer side, one lane per port
    input  wire logic [3:0]                      RX_BIT_EN,
    input  wire logic [3:0][rbs_pkg::CH_W-1:0]   RX_CHANNEL,
    input  wire logic [3:0][rbs_pkg::BITPOS_W-1:0] RX_BIT_POS,
    input  wire logic [3:0]                      LINE_IN_POSITIVE,
    input  wire logic [3:0]                      LINE_IN_NEGATIVE,
    input  wire logic [3:0]                      BACKPLANE_SERIAL_IN,
    output logic      [3:0]                      RX_READY,
    // pattern tester side
    output logic      [3:0]                      TESTER_DATA,
    output logic      [3:0]                      TESTER_VALID,
    input  wire logic [3:0]                      TESTER_READY
);
    localparam int NP = rbs_pkg::NUM_PORTS;

    // the lane vectors above are four wide
    if (NP != 4 || FIFO_DEPTH < 2) begin : g_bad_cfg
        $error("rbs_top: unsupported port count or fifo depth");
    end

    ////////////////////////////////////////////////////////////////////
    // apb address decode
    ////////////////////////////////////////////////////////////////////

    logic [10:0]                 idx;       // register index
    logic [rbs_pkg::PORT_W-1:0]  port_sel;  // which port slice
    logic [rbs_pkg::OFF_W-1:0]   reg_off;   // index inside the port
    logic                        aligned;   // word aligned access
    logic                        setup;     // first apb cycle
    logic                        access_wr; // write commits now
    logic [NP-1:0][7:0]          port_rd;   // read data per port
    logic [NP-1:0]               port_hit;  // mapped per port

    // index = port * stride + offset, so port sits above the offset
    assign idx      = PADDR[rbs_pkg::ADDR_W-1:2];
    assign port_sel = idx[10:9];
    assign reg_off  = idx[8:0];
    assign aligned  = (PADDR[1:0] == 2'b00);
    assign setup    = PSEL & ~PENABLE;
    // zero wait states: every access phase completes at once
    assign PREADY    = PSEL & PENABLE;
    assign access_wr = PSEL & PENABLE & PWRITE & aligned;

    ////////////////////////////////////////////////////////////////////
    // read data and error capture
    ////////////////////////////////////////////////////////////////////

    logic [31:0] rdata_r, rdata_nxt;  // read data for access phase
    logic        err_r, err_nxt;      // slave error for access phase

    // sample during setup so the access phase shows registered data
    always_comb begin
        rdata_nxt = rdata_r;
        err_nxt   = err_r;
        if (setup) begin
            err_nxt   = ~aligned | ~port_hit[port_sel];
            rdata_nxt = 32'h0000_0000;
            // narrow registers sit in the low byte, upper bits zero
            if (!PWRITE && aligned && port_hit[port_sel])
                rdata_nxt[7:0] = port_rd[port_sel];
        end
    end

    // register stage of the read path
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_r <= 32'h0000_0000;
            err_r   <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            err_r   <= err_nxt;
        end
    end

    assign PRDATA  = rdata_r;
    assign PSLVERR = PREADY & err_r;

    ////////////////////////////////////////////////////////////////////
    // per-port register slice and data path
    ////////////////////////////////////////////////////////////////////

    for (genvar p = 0; p < NP; p++) begin : g_port
        rbs_cfg_if cfg ();
        logic       wr_p;      // write strobe for this slice
        logic       src_bit;   // chosen source bit
        logic       ch_on;     // current timeslot selected
        logic       bit_kept;  // current bit position not suppressed
        logic       take;      // bit goes to the tester
        logic       head_vld;  // fifo holds at least one bit

        // only the addressed port takes the write
        assign wr_p = access_wr
                      && (port_sel == (rbs_pkg::PORT_W)'(p));

        rbs_port_regs u_regs (
            .clk     (SYS_CLK),
            .rst_n   (NRST),
            .wr_en   (wr_p),
            .off     (reg_off),
            .wr_data (PWDATA[7:0]),
            .rd_data (port_rd[p]),
            .hit     (port_hit[p]),
            .cfg     (cfg.owner)
        );

        // line side: a mark on either rail decodes to a one
        always_comb begin
            if (cfg.direction == rbs_pkg::DIR_BACKPLANE)
                src_bit = BACKPLANE_SERIAL_IN[p];
            else
                src_bit = LINE_IN_POSITIVE[p] | LINE_IN_NEGATIVE[p];
        end

        // each timeslot looks up its own bit, so any mix works
        assign ch_on    = cfg.chsel[RX_CHANNEL[p]];
        // position 7 is channel bit 8, the msb
        assign bit_kept = ~cfg.suppress[RX_BIT_POS[p]];
        // receive bit timing alone paces the path
        assign take     = RX_BIT_EN[p] & cfg.enable
                          & ch_on & bit_kept;

        // disabling flushes queued bits so nothing stale is qualified
        rbs_fifo #(
            .WIDTH (1),
            .DEPTH (FIFO_DEPTH)
        ) u_fifo (
            .clk       (SYS_CLK),
            .rst_n     (NRST),
            .clear     (~cfg.enable),
            .in_valid  (take),
            .in_ready  (RX_READY[p]),
            .in_data   (src_bit),
            .out_valid (head_vld),
            .out_ready (TESTER_READY[p]),
            .out_data  (TESTER_DATA[p])
        );

        // qualifier drops with enable, not one cycle later with the flush
        assign TESTER_VALID[p] = head_vld & cfg.enable;
    end
endmodule

// File: testbench/rbs_tester_model.sv
`timescale 1ns/1ps
// pattern tester stand-in: logs a bit per port when valid meets ready
module rbs_tester_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] valid,
    input  wire logic [3:0] data,
    input  wire logic [3:0] stall,
    input  wire logic [3:0] slow,
    output logic      [3:0] ready
);
    logic ph;          // a slow port accepts every other cycle
    logic got [4][$];  // received bits, oldest first
    assign ready = ~stall & (~slow | {4{ph}});
    // log at the edge where the handshake completes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) ph <= 1'b0;
        else begin
            ph <= ~ph;
            for (int p = 0; p < 4; p++) begin
                if (valid[p] && ready[p]) got[p].push_back(data[p]);
            end
        end
    end
endmodule

// File: testbench/rbs_top_props.sv
`timescale 1ns/1ps
// port 0 of the selector against a shadow of its own registers
module rbs_top_props (
    input wire logic              SYS_CLK,
    input wire logic              NRST,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [12:0]       PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    input wire logic [3:0]        RX_BIT_EN,
    input wire logic [3:0][4:0]   RX_CHANNEL,
    input wire logic [3:0][2:0]   RX_BIT_POS,
    input wire logic [3:0]        LINE_IN_POSITIVE,
    input wire logic [3:0]        LINE_IN_NEGATIVE,
    input wire logic [3:0]        BACKPLANE_SERIAL_IN,
    input wire logic [3:0]        RX_READY,
    input wire logic [3:0]        TESTER_DATA,
    input wire logic [3:0]        TESTER_VALID,
    input wire logic [3:0]        TESTER_READY
);
    logic        wr_c;  // committed write
    logic        en_r;  // shadow enable
    logic        dir_r; // shadow direction
    logic [7:0]  sup_r; // shadow suppress mask
    logic [31:0] cs_r;  // shadow channel selects
    logic        src;   // bit the tester should see
    logic        take;  // bit qualifies for the tester
    assign wr_c = PSEL & PENABLE & PWRITE;
    assign src = dir_r ? BACKPLANE_SERIAL_IN[0]
                       : LINE_IN_POSITIVE[0] | LINE_IN_NEGATIVE[0];
    assign take = RX_BIT_EN[0] & en_r & cs_r[RX_CHANNEL[0]]
                & ~sup_r[RX_BIT_POS[0]];
    // shadow follows writes at the same edge the slave commits them
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) {en_r, dir_r, sup_r, cs_r} <= '0;
        else if (wr_c && PADDR == 13'h228) begin
            {dir_r, en_r} <= {PWDATA[2], PWDATA[0]};
        end else if (wr_c && PADDR == 13'h22c) sup_r <= PWDATA[7:0];
        else if (wr_c && PADDR[12:4] == 9'h035) begin
            cs_r[PADDR[3:2]*8 +: 8] <= PWDATA[7:0];
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    a_ready_needs_en: assert property (!en_r |-> !RX_READY[0])
        else $error("rx ready while port disabled");
    a_take_reaches: assert property (take && !TESTER_VALID[0] |=>
        !en_r || (TESTER_VALID[0] && TESTER_DATA[0] == $past(src)))
        else $error("kept bit missing or wrong at tester");
    a_drop_unkept: assert property (
        RX_BIT_EN[0] && !take && !TESTER_VALID[0] |=> !TESTER_VALID[0])
        else $error("unselected or suppressed bit reached tester");
    a_hold_head: assert property (TESTER_VALID[0] && !TESTER_READY[0]
        |=> !en_r || (TESTER_VALID[0] && $stable(TESTER_DATA[0])))
        else $error("tester head changed while not taken");
    a_flush_on_off: assert property ($fell(en_r)
        |-> ##[0:1] !TESTER_VALID[0]) else $error("no flush on disable");
    a_read_select: assert property (PSEL && PENABLE && !PWRITE
        && PADDR[12:4] == 9'h035 |-> PRDATA == {24'h0,
        cs_r[PADDR[3:2]*8 +: 8]}) else $error("select readback wrong");
    a_read_ctrl: assert property (PSEL && PENABLE && !PWRITE
        && PADDR == 13'h228 |-> PRDATA == {29'h0, dir_r, 1'b0, en_r})
        else $error("control readback wrong");
    a_misalign_err: assert property (PSEL && PENABLE
        && PADDR[1:0] != 2'h0 |-> PSLVERR && PREADY)
        else $error("misaligned access not refused");
    a_err_in_access: assert property (PSLVERR |-> PSEL && PENABLE)
        else $error("error outside access phase");
endmodule
bind rbs_top rbs_top_props u_props (.*);

// File: testbench/tb.sv
`timescale 1ns/1ps
// drives apb and the port 0 framer lane, checks what the tester logs
module tb;
    logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [12:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr;
    logic [3:0] rx_en = '0, lp = '0, ln = '0, bp = '0, rx_ready;
    logic [3:0][4:0] rx_ch = '0;
    logic [3:0][2:0] rx_pos = '0;
    logic [3:0] t_data, t_valid, t_ready, stall = '0, slow = '0;
    int failures = 0, n_tests = 0, cyc = 0;
    logic q_exp [$];               // bits the tester should get
    logic en = 0, dir = 0;         // bench view of port 0 config
    logic [7:0] sup = '0;
    logic [31:0] cs = '0;
    logic [8:0] offs [6] = '{rbs_pkg::OFF_CTRL, rbs_pkg::OFF_SUPP,
        rbs_pkg::OFF_CSEL1, rbs_pkg::OFF_CSEL2, rbs_pkg::OFF_CSEL3,
        rbs_pkg::OFF_CSEL4};
    always #(rbs_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
    rbs_top uut (.SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RX_BIT_EN(rx_en), .RX_CHANNEL(rx_ch), .RX_BIT_POS(rx_pos),
        .LINE_IN_POSITIVE(lp), .LINE_IN_NEGATIVE(ln),
        .BACKPLANE_SERIAL_IN(bp), .RX_READY(rx_ready), .TESTER_DATA(t_data),
        .TESTER_VALID(t_valid), .TESTER_READY(t_ready));
    rbs_tester_model m (.clk(sys_clk), .rst_n(nrst), .valid(t_valid),
        .data(t_data), .stall(stall), .slow(slow), .ready(t_ready));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // a hang is cut short here
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            print_verdict;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [12:0] a,
                       input logic [7:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge sys_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    function automatic logic [12:0] ra(input int p, input logic [8:0] i);
        return 13'(4 * (p * rbs_pkg::PORT_STRIDE + i));
    endfunction
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        check(32'(e), 32'h0);
    endtask
    task automatic rd(input logic [12:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        check(r, x);
        check(32'(e), 32'(xe));
    endtask
    // program port 0; unused control bits always written as zero
    task automatic cfg(input logic e_, input logic d_,
                       input logic [7:0] s_, input logic [31:0] c_);
        en = e_; dir = d_; sup = s_; cs = c_;
        wr(ra(0, rbs_pkg::OFF_SUPP), s_);
        for (int i = 0; i < 4; i++) wr(ra(0, offs[i+2]), c_[i*8 +: 8]);
        wr(ra(0, rbs_pkg::OFF_CTRL), {5'h0, d_, 1'b0, e_});
    endtask
    // one framer bit; rails differ from backplane so the source shows
    task automatic send(input int ch, input int pos, input logic v);
        @(posedge sys_clk);
        rx_en[0] <= 1; rx_ch[0] <= 5'(ch); rx_pos[0] <= 3'(pos);
        lp[0] <= v & pos[0]; ln[0] <= v & ~pos[0]; bp[0] <= ~v;
        #1;
        if (en && cs[ch] && !sup[pos] && rx_ready[0]) begin
            q_exp.push_back(dir ? ~v : v);
        end
    endtask
    // stop sending, let the tester empty the buffer, compare its log
    task automatic drain;
        @(posedge sys_clk);
        rx_en[0] <= 0;
        for (int i = 0; i < 200 && t_valid[0] !== 1'b0; i++) begin
            @(posedge sys_clk);
        end
        repeat (2) @(posedge sys_clk);
        check(32'(m.got[0].size()), 32'(q_exp.size()));
        while (q_exp.size() > 0 && m.got[0].size() > 0) begin
            check(32'(m.got[0].pop_front()), 32'(q_exp.pop_front()));
        end
        q_exp.delete();
        m.got[0].delete();
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1;
        foreach (offs[i]) rd(ra(0, offs[i]), 32'h0, 1'b0);
        $display("test reset_values done");
        wr(ra(1, rbs_pkg::OFF_CSEL4), 8'ha5);
        rd(ra(1, rbs_pkg::OFF_CSEL4), 32'ha5, 1'b0);
        rd(ra(0, rbs_pkg::OFF_CSEL4), 32'h0, 1'b0);
        wr(ra(3, rbs_pkg::OFF_CTRL), 8'h05);
        rd(ra(3, rbs_pkg::OFF_CTRL), 32'h05, 1'b0);
        rd(ra(0, rbs_pkg::OFF_CTRL) | 13'h1, 32'h0, 1'b1);
        rd(13'h0004, 32'h0, 1'b1);
        $display("test register_map done");
        cfg(1'b1, rbs_pkg::DIR_LINE, 8'h01, 32'h8000_0021);
        foreach (offs[c]) for (int p = 0; p < 8; p++)
            send(c * 31 / 5, p, 1'((c + p) >> 1));
        drain;
        $display("test line_source done");
        slow <= 4'h1;
        cfg(1'b1, rbs_pkg::DIR_BACKPLANE, 8'h80, 32'hffff_ffff);
        for (int c = 0; c < 32; c++) send(c, c % 8, c[1]);
        drain;
        $display("test backplane_all done");
        stall <= 4'h1;
        repeat (6) send(3, 1, 1'b1);
        @(posedge sys_clk);
        rx_en[0] <= 0;
        #1;
        check(32'(rx_ready[0]), 32'h0);
        check(32'(q_exp.size()), 32'(rbs_pkg::FIFO_DEPTH));
        stall <= 4'h0;
        drain;
        $display("test fifo_full done");
        stall <= 4'h1;
        repeat (2) send(3, 1, 1'b1);
        cfg(1'b0, rbs_pkg::DIR_LINE, 8'h00, 32'hffff_ffff);
        q_exp.delete();
        repeat (4) send(5, 2, 1'b1);
        stall <= 4'h0;
        drain;
        $display("test disabled done");
        print_verdict;
    end
endmodule
